// file: test/cxk_cop_model.sv
// Behavioural second coprocessor driving the exception link of cxk_port.
// Assumes bench requests change just after a rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none

module cxk_cop_model
    import cxk_pkg::*;
(
    // Clock
    input  wire logic       core_clk,
    // Bench requests
    input  wire logic       excGo,
    input  wire logic       excFlag,
    input  wire logic [4:0] excCode,
    // Link to the core
    output var  cxk_exc_t   copExc
);
    // Idle lines churn so a design that ignores the strobe is caught
    logic [5:0] junk_q = 6'h15;

    always @(posedge core_clk) begin
        junk_q <= junk_q + 6'h0B;
    end

    assign copExc = excGo ? {1'b1, excFlag, excCode} : {1'b0, junk_q};
endmodule : cxk_cop_model

`default_nettype wire

// file: test/cxk_port_tb.sv
// Self-checking bench for cxk_port against an integer reference model.
// Assumes cxk_pkg and cxk_cop_model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module cxk_port_tb;
    import cxk_pkg::*;
    logic        core_clk = 1'b0, arst_n = 1'b0, excGo = 1'b0;
    logic        excFlag = 1'b0, nullReq = 1'b0, nullFlagIn = 1'b0;
    logic        killReq = 1'b0, killAbort = 1'b0, regWr = 1'b0;
    logic        regRd = 1'b0, excPending, irq;
    logic [4:0]  excCode = 5'h00, excCause;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic [4:0]  tbl [3] = '{5'h0A, 5'h11, 5'h12};
    cxk_exc_t    copExc;
    cxk_null_t   copNull;
    cxk_kill_t   copKill;
    int failures = 0, checks = 0, pend = 0, cause = 0, st = 0, en = 0, ctl = 0;

    cxk_cop_model cop_u (.core_clk(core_clk), .excGo(excGo),
        .excFlag(excFlag), .excCode(excCode), .copExc(copExc));
    cxk_port dut_u (.core_clk(core_clk), .arst_n(arst_n), .copExc(copExc),
        .copNull(copNull), .copKill(copKill), .nullReq(nullReq),
        .nullFlagIn(nullFlagIn), .killReq(killReq), .killAbort(killAbort),
        .excPending(excPending), .excCause(excCause), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .irq(irq));

    always #10 core_clk = ~core_clk;

    task automatic chk(input string what, input logic [31:0] exp, got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic give_verdict;
        $display("Checks %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        chk("regRdata", exp, regRdata);
    endtask : reg_read

    // One transfer: 0 exception, 1 nullify, 2 kill
    task automatic step(input int k, input logic f, input logic [4:0] c);
        logic [1:0] kt;
        @(posedge core_clk);
        excGo     <= (k == 0);
        excFlag   <= f;
        excCode   <= c;
        nullReq   <= (k == 1);
        killReq   <= (k == 2);
        nullFlagIn <= f;
        killAbort <= f;
        @(posedge core_clk);
        excGo   <= 1'b0;
        nullReq <= 1'b0;
        killReq <= 1'b0;
        #1;
        if (k == 0 && f) begin
            pend  = 1;
            cause = c;
            st |= 1;
            if (c != 5'h0A && c != 5'h11 && c != 5'h12)
                st |= 2;
        end else if (k == 1) begin
            chk("copNull", {1'b1, f}, copNull);
            if (f)
                pend = 0;
            st |= f ? 4 : 0;
        end else if (k == 2) begin
            kt = f ? (pend ? 2'h3 : 2'h2) : ((ctl && pend) ? 2'h3 : 2'h0);
            chk("copKill", {1'b1, kt}, copKill);
            st |= kt[1] ? 8 : 0;
            pend = 0;
        end
        chk("excPending", pend, excPending);
        chk("excCause", cause, excCause);
        @(posedge core_clk);
        #1;
        chk("strobes", 0, {copNull.strobe, copKill.strobe});
        // Nullify and kill status bits land one cycle after the report
        chk("irq", |(st & en), irq);
    endtask : step

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int k;
        logic [4:0] c;
        void'($urandom(57));
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        reg_read(8'h04, 0);
        reg_read(8'h10, 0);
        for (int i = 0; i < 200; i++) begin
            k = $urandom % 3;
            c = (i % 4 == 3) ? 5'($urandom) : tbl[i % 3];
            step(k, 1'($urandom), c);
            if (i % 8 == 7) begin
                ctl = $urandom % 2;
                en  = $urandom % 16;
                reg_write(8'h10, ctl);
                reg_write(8'h04, en);
                reg_read(8'h04, en);
                reg_read(8'h10, ctl);
                reg_read(8'h00, st);
                reg_read(8'h0C, cause);
                reg_read(8'h08, 0);
                reg_read(8'h14, 0);
                chk("irq", |(st & en), irq);
                k = $urandom % 16;
                reg_write(8'h08, k);
                st &= ~k;
            end
        end
        give_verdict;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        give_verdict;
    end
endmodule : cxk_port_tb

`default_nettype wire

// file: verilog/cxk_map.svh
// Constants for the coprocessor exception / nullify / kill port.
// Assumes byte addresses on a plain 8-bit register port, 32-bit data.
`ifndef CXK_MAP_SVH
`define CXK_MAP_SVH

`define CXK_ADDR_W        8
`define CXK_DATA_W        32
`define CXK_OFS_STATUS    8'h00
`define CXK_OFS_IRQ_EN    8'h04
`define CXK_OFS_IRQ_CLR   8'h08
`define CXK_OFS_CAUSE     8'h0C
`define CXK_OFS_CTRL      8'h10

`define CXK_EVT_W         4
`define CXK_EVT_EXC       0
`define CXK_EVT_BADCAUSE  1
`define CXK_EVT_NULLIFIED 2
`define CXK_EVT_KILLED    3
`define CXK_CTRL_KOE      0
`define CXK_CTRL_RST      1'h0
`define CXK_IRQ_EN_RST    4'h0

`define CXK_CAUSE_ILLEGAL_OP 5'h0A
`define CXK_CAUSE_IMPL_SPEC  5'h11
`define CXK_CAUSE_SECOND_COPROCESSOR_ERR   5'h12

`define CXK_KILL_NONE     2'h0
`define CXK_KILL_OTHER    2'h2
`define CXK_KILL_EXC      2'h3

`endif

// file: verilog/cxk_pkg.sv
// Types for the coprocessor exception / nullify / kill port.
// Assumes cxk_map.svh is on the include path.
`default_nettype none
`include "cxk_map.svh"

package cxk_pkg;

    typedef struct packed {
        logic       strobe;
        logic       flag;
        logic [4:0] cause;
    } cxk_exc_t;

    typedef struct packed {
        logic strobe;
        logic flag;
    } cxk_null_t;

    typedef struct packed {
        logic       strobe;
        logic [1:0] killType;
    } cxk_kill_t;

endpackage : cxk_pkg

`default_nettype wire

// file: verilog/cxk_port.sv
// Core-side end of the second coprocessor exception / nullify / kill port.
// Assumes the coprocessor runs on core_clk, so its inputs need no synchroniser.
//
// Overview of operation
// - Exception counts only when flag and strobe are both high.
// - Cause code is sampled only when strobe and flag are both high.
// - Only causes 01010, 10001, 10010 are legal; others flagged as errors.
// - Nullify flag high ends the instruction; no further transactions for it.
// - Core reports killing of every issued instruction via strobe and type.
// - Kill strobe is high in the cycle the kill type is valid.
// - Kill types 00/01 commit, 10 killed otherwise, 11 killed by exception.
`timescale 1ns/1ps
`default_nettype none
`include "cxk_map.svh"

module cxk_port
    import cxk_pkg::*;
(
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   arst_n,
    // Coprocessor link
    input  wire cxk_exc_t               copExc,
    output var  cxk_null_t              copNull,
    output var  cxk_kill_t              copKill,
    // Core pipeline side
    input  wire logic                   nullReq,
    input  wire logic                   nullFlagIn,
    input  wire logic                   killReq,
    input  wire logic                   killAbort,
    output logic                        excPending,
    output logic [4:0]                  excCause,
    // Register port
    input  wire logic [`CXK_ADDR_W-1:0] regAddr,
    input  wire logic [`CXK_DATA_W-1:0] regWdata,
    input  wire logic                   regWr,
    input  wire logic                   regRd,
    output logic [`CXK_DATA_W-1:0]      regRdata,
    // Interrupt
    output logic                        irq
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    logic [1:0] rstPipe_q;
    logic       rstN;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) rstPipe_q <= 2'h0;
        else         rstPipe_q <= {rstPipe_q[0], 1'h1};
    end
    assign rstN = rstPipe_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Exception intake
    logic       excHit;
    logic       causeLegal;
    logic       excPend_q;
    logic       excPend_d;
    logic [4:0] cause_q;
    logic       nullEnds;

    assign excHit     = copExc.strobe & copExc.flag;
    assign causeLegal = (copExc.cause == `CXK_CAUSE_ILLEGAL_OP) ||
                        (copExc.cause == `CXK_CAUSE_IMPL_SPEC)  ||
                        (copExc.cause == `CXK_CAUSE_SECOND_COPROCESSOR_ERR);
    assign nullEnds   = nullReq & nullFlagIn;
    // New exception wins over a same-cycle end of instruction
    assign excPend_d  = excHit | (excPend_q & ~killReq & ~nullEnds);

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) excPend_q <= 1'h0;
        else       excPend_q <= excPend_d;
    end

    // cause captured only on a real exception
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN)       cause_q <= 5'h00;
        else if (excHit) cause_q <= copExc.cause;
    end

    assign excPending = excPend_q;
    assign excCause   = cause_q;

    ////////////////////////////////////////////////////////////////////////
    // Nullify and kill drive
    logic       ctrlKoe_q;
    logic       excSeen;
    logic [1:0] killType_d;
    cxk_null_t  null_q;
    cxk_kill_t  kill_q;

    assign excSeen    = excPend_q | excHit;
    assign killType_d = killAbort ? (excSeen ? `CXK_KILL_EXC : `CXK_KILL_OTHER)
                      : ((ctrlKoe_q & excSeen) ? `CXK_KILL_EXC
                                               : `CXK_KILL_NONE);

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) null_q <= '0;
        else       null_q <= '{strobe: nullReq, flag: nullReq & nullFlagIn};
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN)        kill_q <= '0;
        else if (killReq) kill_q <= '{strobe: 1'h1, killType: killType_d};
        else              kill_q <= '0;
    end

    assign copNull = null_q;
    assign copKill = kill_q;

    ////////////////////////////////////////////////////////////////////////
    // Registers and interrupt
    logic [`CXK_EVT_W-1:0]  events;
    logic [`CXK_EVT_W-1:0]  sticky_q;
    logic [`CXK_EVT_W-1:0]  irqEn_q;
    logic [`CXK_EVT_W-1:0]  clrMask;
    logic [`CXK_DATA_W-1:0] rdMux;
    logic [`CXK_DATA_W-1:0] rdata_q;
    logic                   selStatus;
    logic                   selEn;
    logic                   selClr;
    logic                   selCause;
    logic                   selCtrl;

    assign selStatus = (regAddr == `CXK_OFS_STATUS);
    assign selEn     = (regAddr == `CXK_OFS_IRQ_EN);
    assign selClr    = (regAddr == `CXK_OFS_IRQ_CLR);
    assign selCause  = (regAddr == `CXK_OFS_CAUSE);
    assign selCtrl   = (regAddr == `CXK_OFS_CTRL);

    assign events[`CXK_EVT_EXC]       = excHit;
    assign events[`CXK_EVT_BADCAUSE]  = excHit & ~causeLegal;
    assign events[`CXK_EVT_NULLIFIED] = null_q.strobe & null_q.flag;
    assign events[`CXK_EVT_KILLED]    = kill_q.strobe & kill_q.killType[1];

    assign clrMask = (regWr & selClr) ? regWdata[`CXK_EVT_W-1:0] : '0;

    // Set wins over a same-cycle clear, so no event is lost
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) sticky_q <= '0;
        else       sticky_q <= (sticky_q & ~clrMask) | events;
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN)              irqEn_q <= `CXK_IRQ_EN_RST;
        else if (regWr & selEn) irqEn_q <= regWdata[`CXK_EVT_W-1:0];
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN)                ctrlKoe_q <= `CXK_CTRL_RST;
        else if (regWr & selCtrl) ctrlKoe_q <= regWdata[`CXK_CTRL_KOE];
    end

    // Clear register is write-only; unmapped addresses read zero
    assign rdMux = selStatus ? {{(`CXK_DATA_W-`CXK_EVT_W){1'b0}}, sticky_q}
                 : selEn     ? {{(`CXK_DATA_W-`CXK_EVT_W){1'b0}}, irqEn_q}
                 : selCause  ? {27'h0000000, cause_q}
                 : selCtrl   ? {31'h00000000, ctrlKoe_q}
                 : '0;

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) rdata_q <= '0;
        else       rdata_q <= regRd ? rdMux : '0;
    end

    assign regRdata = rdata_q;
    assign irq      = |(sticky_q & irqEn_q);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_exc_capture: assert property (@(posedge core_clk) disable iff (!rstN)
        excHit |=> sticky_q[`CXK_EVT_EXC] && excPend_q)
        else $error("exception not recorded");
    a_cause_hold: assert property (@(posedge core_clk) disable iff (!rstN)
        !excHit |=> $stable(cause_q))
        else $error("cause changed without a valid exception");
    a_bad_cause: assert property (@(posedge core_clk) disable iff (!rstN)
        (excHit && !causeLegal) |=> sticky_q[`CXK_EVT_BADCAUSE])
        else $error("reserved cause not flagged");
    a_null_follow: assert property (@(posedge core_clk) disable iff (!rstN)
        nullReq |=> copNull.strobe && (copNull.flag == $past(nullFlagIn)))
        else $error("nullify report missing or wrong");
    a_null_pair: assert property (@(posedge core_clk) disable iff (!rstN)
        copNull.flag |-> copNull.strobe)
        else $error("nullify flag without strobe");
    a_null_ends: assert property (@(posedge core_clk) disable iff (!rstN)
        (nullEnds && !excHit) |=> !excPend_q)
        else $error("nullified instruction still pending");
    a_kill_strobe: assert property (@(posedge core_clk) disable iff (!rstN)
        killReq |=> copKill.strobe ##1 (copKill.strobe == $past(killReq)))
        else $error("kill strobe wrong");
    a_kill_exc: assert property (@(posedge core_clk) disable iff (!rstN)
        (killReq && killAbort && excPend_q) |=> copKill.killType == 2'h3)
        else $error("exception kill type wrong");
    a_kill_other: assert property (@(posedge core_clk) disable iff (!rstN)
        (killReq && killAbort && !excSeen) |=> copKill.killType == 2'h2)
        else $error("plain kill type wrong");
    a_kill_idle: assert property (@(posedge core_clk) disable iff (!rstN)
        !copKill.strobe |-> copKill.killType == 2'h0)
        else $error("kill type driven without strobe");
    a_kill_commit: assert property (@(posedge core_clk) disable iff (!rstN)
        (killReq && !killAbort && !(ctrlKoe_q && excSeen))
            |=> copKill.killType == `CXK_KILL_NONE)
        else $error("commit kill type wrong");

endmodule : cxk_port

`default_nettype wire
